// File: rtl/accr_regs.vh
// register offsets, fields, reset values and gain table for channel 4 cal
`ifndef ACCR_REGS_VH
`define ACCR_REGS_VH

// register indexes; byte address is four times the index
`define ACCR_IDX_FINE_GAIN      8'h60
`define ACCR_IDX_PHASE_DELAY    8'h61
`define ACCR_IDX_COMMON_CFG     8'h62

// reset values
`define ACCR_RST_FINE_GAIN      8'h80
`define ACCR_RST_PHASE_DELAY    8'h00
`define ACCR_RST_COMMON_CFG     8'h00

// field positions
`define ACCR_FGAIN_MSB          7
`define ACCR_FGAIN_LSB          4
`define ACCR_PDLY_MSB           7
`define ACCR_PDLY_LSB           2
`define ACCR_CMTRIM_MSB         5
`define ACCR_CMTRIM_LSB         4
`define ACCR_INVERT_BIT         2

// common-mode trim codes
`define ACCR_CMTRIM_NONE        2'h0
`define ACCR_CMTRIM_500K        2'h1
`define ACCR_CMTRIM_250K        2'h2

// fine gain coefficients, unsigned q1.14, 0.1 db steps from -0.8 db
`define ACCR_GAIN_M08           16'h3a5e
`define ACCR_GAIN_M07           16'h3b0b
`define ACCR_GAIN_M06           16'h3bba
`define ACCR_GAIN_M05           16'h3c6b
`define ACCR_GAIN_M04           16'h3d1f
`define ACCR_GAIN_M03           16'h3dd4
`define ACCR_GAIN_M02           16'h3e8b
`define ACCR_GAIN_M01           16'h3f44
`define ACCR_GAIN_UNITY         16'h4000
`define ACCR_GAIN_P01           16'h40be
`define ACCR_GAIN_P02           16'h417e
`define ACCR_GAIN_P03           16'h4240
`define ACCR_GAIN_P04           16'h4304
`define ACCR_GAIN_P05           16'h43cb
`define ACCR_GAIN_P06           16'h4494
`define ACCR_GAIN_P07           16'h455f
`define ACCR_GAIN_FRAC          14

`endif

// File: rtl/accr_delay_line.v
// tapped delay line stepping once per modulator clock tick
`timescale 1ns/1ps
`default_nettype none

module accr_delay_line
#(
	parameter DEPTH = 63,
	parameter SELW  = 6
)
(
	input  wire            clk,
	input  wire            resetn,
	input  wire            tick,
	input  wire            bit_in,
	input  wire [SELW-1:0] delay,
	output reg             bit_out
);

	// taps[0] is the undelayed bit, taps[k] is k ticks old
	wire [DEPTH:0] taps;

	assign taps[0] = bit_in;

	////////////////////////////////////////////////////////////////////
	// one shift stage per tap above taps[0]
	genvar g;
	generate
		for (g = 1; g <= DEPTH; g = g + 1)
		begin : stage
			reg held;
			always @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					held <= 1'b0;
				else if (tick)
					held <= taps[g-1];
			end
			assign taps[g] = held;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// tap select, registered on the tick
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			bit_out <= 1'b0;
		else if (tick)
			bit_out <= taps[delay];
	end

endmodule

`default_nettype wire

// File: rtl/accr_top.v
// channel 4 calibration and adc common configuration registers with datapath
`timescale 1ns/1ps
`default_nettype none
`include "accr_regs.vh"

module accr_top
#(
	parameter SAMPLE_W = 24
)
(
	input  wire                CLK,
	input  wire                RESETN,
	// avalon-mm slave
	input  wire [9:0]          AVS_ADDRESS,
	input  wire                AVS_READ,
	input  wire                AVS_WRITE,
	input  wire [31:0]         AVS_WRITEDATA,
	output reg  [31:0]         AVS_READDATA,
	output reg                 AVS_WAITREQUEST,
	// modulator bit stream from the analog front end
	input  wire                MOD_TICK,
	input  wire                MOD_BIT,
	output reg                 MOD_BIT_DELAYED,
	// filtered channel 4 samples
	input  wire [SAMPLE_W-1:0] SAMPLE_IN,
	input  wire                SAMPLE_IN_VALID,
	output reg  [SAMPLE_W-1:0] SAMPLE_OUT,
	output reg                 SAMPLE_OUT_VALID,
	// analog input network controls
	output reg                 CM_PULLUP_500K,
	output reg                 CM_PULLUP_250K,
	// settings for downstream logic
	output reg  [3:0]          CH4_FINE_GAIN_CODE,
	output reg  [5:0]          CH4_PHASE_DELAY,
	output reg                 DATA_INVERT
);

	localparam PROD_W = SAMPLE_W + 17;

	// reset images of the three registers, fields sliced from these
	localparam [7:0] GAIN_RST   = `ACCR_RST_FINE_GAIN;
	localparam [7:0] PHASE_RST  = `ACCR_RST_PHASE_DELAY;
	localparam [7:0] COMMON_RST = `ACCR_RST_COMMON_CFG;

	////////////////////////////////////////////////////////////////////
	// register fields, reserved bits are not stored
	reg  [3:0]  ch4_fine_gain_code;
	reg  [5:0]  ch4_phase_delay;
	reg  [1:0]  input_cm_trim;
	reg         data_invert;

	// bus decode
	wire [7:0]  reg_index;
	wire        hit_gain;
	wire        hit_phase;
	wire        hit_common;
	wire        bus_write;
	reg  [7:0]  next_readdata;

	assign reg_index  = AVS_ADDRESS[9:2];
	assign hit_gain   = (reg_index == `ACCR_IDX_FINE_GAIN);
	assign hit_phase  = (reg_index == `ACCR_IDX_PHASE_DELAY);
	assign hit_common = (reg_index == `ACCR_IDX_COMMON_CFG);
	// a write takes effect on the edge where waitrequest is low
	assign bus_write  = AVS_WRITE & ~AVS_WAITREQUEST;

	////////////////////////////////////////////////////////////////////
	// waitrequest drops for one cycle per request
	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			AVS_WAITREQUEST <= 1'b1;
		else if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST)
			AVS_WAITREQUEST <= 1'b0;
		else
			AVS_WAITREQUEST <= 1'b1;
	end

	always @*
	begin
		next_readdata = 8'h00;
		if (hit_gain)
			next_readdata[`ACCR_FGAIN_MSB:`ACCR_FGAIN_LSB] =
				ch4_fine_gain_code;
		if (hit_phase)
			next_readdata[`ACCR_PDLY_MSB:`ACCR_PDLY_LSB] = ch4_phase_delay;
		if (hit_common)
		begin
			next_readdata[`ACCR_CMTRIM_MSB:`ACCR_CMTRIM_LSB] = input_cm_trim;
			next_readdata[`ACCR_INVERT_BIT] = data_invert;
		end
	end

	// read data captured while waiting, stands at the answer edge
	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			AVS_READDATA <= 32'h00000000;
		else if (AVS_READ & AVS_WAITREQUEST)
			AVS_READDATA <= {24'h000000, next_readdata};
	end

	////////////////////////////////////////////////////////////////////
	// fine gain reset 0x80
	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			ch4_fine_gain_code <=
				GAIN_RST[`ACCR_FGAIN_MSB:`ACCR_FGAIN_LSB];
		else if (bus_write & hit_gain)
			ch4_fine_gain_code <=
				AVS_WRITEDATA[`ACCR_FGAIN_MSB:`ACCR_FGAIN_LSB];
	end

	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			ch4_phase_delay <= PHASE_RST[`ACCR_PDLY_MSB:`ACCR_PDLY_LSB];
		else if (bus_write & hit_phase)
			ch4_phase_delay <= AVS_WRITEDATA[`ACCR_PDLY_MSB:`ACCR_PDLY_LSB];
	end

	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			input_cm_trim <=
				COMMON_RST[`ACCR_CMTRIM_MSB:`ACCR_CMTRIM_LSB];
			data_invert   <= COMMON_RST[`ACCR_INVERT_BIT];
		end
		else if (bus_write & hit_common)
		begin
			input_cm_trim <=
				AVS_WRITEDATA[`ACCR_CMTRIM_MSB:`ACCR_CMTRIM_LSB];
			data_invert   <= AVS_WRITEDATA[`ACCR_INVERT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// trim code to pull-up switches
	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			CM_PULLUP_500K <= 1'b0;
			CM_PULLUP_250K <= 1'b0;
		end
		else
		begin
			CM_PULLUP_500K <= (input_cm_trim == `ACCR_CMTRIM_500K);
			CM_PULLUP_250K <= (input_cm_trim == `ACCR_CMTRIM_250K);
		end
	end

	// settings mirrored for downstream filter logic
	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			CH4_FINE_GAIN_CODE <= GAIN_RST[`ACCR_FGAIN_MSB:`ACCR_FGAIN_LSB];
			CH4_PHASE_DELAY    <= PHASE_RST[`ACCR_PDLY_MSB:`ACCR_PDLY_LSB];
			DATA_INVERT        <= COMMON_RST[`ACCR_INVERT_BIT];
		end
		else
		begin
			CH4_FINE_GAIN_CODE <= ch4_fine_gain_code;
			CH4_PHASE_DELAY    <= ch4_phase_delay;
			DATA_INVERT        <= data_invert;
		end
	end

	////////////////////////////////////////////////////////////////////
	// modulator pins pass two flops before use
	reg  [1:0] tick_sync;
	reg  [1:0] bit_sync;
	reg        tick_last;
	wire       tick_rise;
	wire       delayed_bit;

	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			tick_sync <= 2'h0;
			bit_sync  <= 2'h0;
			tick_last <= 1'b0;
		end
		else
		begin
			tick_sync <= {tick_sync[0], MOD_TICK};
			bit_sync  <= {bit_sync[0], MOD_BIT};
			tick_last <= tick_sync[1];
		end
	end

	// one step per modulator clock rising edge
	assign tick_rise = tick_sync[1] & ~tick_last;

	accr_delay_line
	#(
		.DEPTH (63),
		.SELW  (6)
	)
	accr_delay_line_i
	(
		.clk     (CLK),
		.resetn  (RESETN),
		.tick    (tick_rise),
		.bit_in  (bit_sync[1]),
		.delay   (ch4_phase_delay),
		.bit_out (delayed_bit)
	);

	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			MOD_BIT_DELAYED <= 1'b0;
		else
			MOD_BIT_DELAYED <= delayed_bit;
	end

	////////////////////////////////////////////////////////////////////
	// fine gain coefficient lookup
	reg [15:0] gain_coef;

	always @*
	begin
		case (ch4_fine_gain_code)
			4'h0:    gain_coef = `ACCR_GAIN_M08;
			4'h1:    gain_coef = `ACCR_GAIN_M07;
			4'h2:    gain_coef = `ACCR_GAIN_M06;
			4'h3:    gain_coef = `ACCR_GAIN_M05;
			4'h4:    gain_coef = `ACCR_GAIN_M04;
			4'h5:    gain_coef = `ACCR_GAIN_M03;
			4'h6:    gain_coef = `ACCR_GAIN_M02;
			4'h7:    gain_coef = `ACCR_GAIN_M01;
			4'h8:    gain_coef = `ACCR_GAIN_UNITY;
			4'h9:    gain_coef = `ACCR_GAIN_P01;
			4'ha:    gain_coef = `ACCR_GAIN_P02;
			4'hb:    gain_coef = `ACCR_GAIN_P03;
			4'hc:    gain_coef = `ACCR_GAIN_P04;
			4'hd:    gain_coef = `ACCR_GAIN_P05;
			4'he:    gain_coef = `ACCR_GAIN_P06;
			default: gain_coef = `ACCR_GAIN_P07;
		endcase
	end

	// stage 1: scale the sample
	reg  signed [PROD_W-1:0]   product;
	reg                        prod_valid;
	wire signed [PROD_W-1:0]   sample_ext;
	wire signed [PROD_W-1:0]   coef_ext;

	assign sample_ext = {{17{SAMPLE_IN[SAMPLE_W-1]}}, SAMPLE_IN};
	assign coef_ext   = {{(SAMPLE_W+1){1'b0}}, gain_coef};

	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			product    <= {PROD_W{1'b0}};
			prod_valid <= 1'b0;
		end
		else
		begin
			prod_valid <= SAMPLE_IN_VALID;
			if (SAMPLE_IN_VALID)
				product <= sample_ext * coef_ext;
		end
	end

	// stage 2: back to sample scale, saturate, optional negate
	wire signed [PROD_W-1:0]   scaled;
	wire signed [PROD_W-1:0]   max_pos;
	wire signed [PROD_W-1:0]   max_neg;
	reg  signed [PROD_W-1:0]   clipped;
	reg  signed [PROD_W-1:0]   polar;

	assign scaled  = product >>> `ACCR_GAIN_FRAC;
	assign max_pos = {{(PROD_W-SAMPLE_W+1){1'b0}}, {(SAMPLE_W-1){1'b1}}};
	assign max_neg = -max_pos - 1;

	always @*
	begin
		if (scaled > max_pos)
			clipped = max_pos;
		else if (scaled < max_neg)
			clipped = max_neg;
		else
			clipped = scaled;
		if (data_invert)
			polar = (clipped == max_neg) ? max_pos : -clipped;
		else
			polar = clipped;
	end

	// registered sample output
	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			SAMPLE_OUT       <= {SAMPLE_W{1'b0}};
			SAMPLE_OUT_VALID <= 1'b0;
		end
		else
		begin
			SAMPLE_OUT_VALID <= prod_valid;
			if (prod_valid)
				SAMPLE_OUT <= polar[SAMPLE_W-1:0];
		end
	end

endmodule

`default_nettype wire

// File: verification/accr_properties.sv
// concurrent checks on the calibration register block ports
`timescale 1ns/1ps
`default_nettype none
module accr_properties
(
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic [9:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        SAMPLE_IN_VALID,
	input wire logic        SAMPLE_OUT_VALID,
	input wire logic        CM_PULLUP_500K,
	input wire logic        CM_PULLUP_250K,
	input wire logic [3:0]  CH4_FINE_GAIN_CODE,
	input wire logic        DATA_INVERT
);
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	// request decode and the write fields that are followed
	wire       req = AVS_READ | AVS_WRITE;
	wire       wdone = AVS_WRITE & ~AVS_WAITREQUEST;
	wire [7:0] idx = AVS_ADDRESS[9:2];
	wire       inv_bit = AVS_WRITEDATA[2];
	wire [3:0] gain_bits = AVS_WRITEDATA[7:4];
	////////////////////////////////////////////////////////////////////////
	// bus handshake, one wait cycle per request
	a_wait_answer: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("request not answered after one wait cycle");
	a_wait_pulse: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	a_wait_cause: assert property (!AVS_WAITREQUEST |-> $past(req))
		else $error("waitrequest low without a request");
	a_rdata_upper: assert property (AVS_READDATA[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	// settings follow the register two edges after the write, pull-ups never both on
	a_trim_excl: assert property (!(CM_PULLUP_500K && CM_PULLUP_250K))
		else $error("both pull-ups connected");
	a_invert_copy: assert property (wdone && idx == 8'h62 |->
		##2 DATA_INVERT == $past(inv_bit, 2))
		else $error("invert setting does not follow write");
	a_gain_copy: assert property (wdone && idx == 8'h60 |->
		##2 CH4_FINE_GAIN_CODE == $past(gain_bits, 2))
		else $error("gain code does not follow write");
	// sample path latency
	a_out_latency: assert property (SAMPLE_IN_VALID |-> ##2 SAMPLE_OUT_VALID)
		else $error("sample out valid missing");
	a_out_cause: assert property (SAMPLE_OUT_VALID |-> $past(SAMPLE_IN_VALID, 2))
		else $error("sample out valid without input");
	c_write: cover property (wdone);
	c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
	c_inv_out: cover property (SAMPLE_OUT_VALID && DATA_INVERT);
endmodule
`default_nettype wire

// File: verification/test_accr_top.sv
// self-checking bench for the calibration register block
`timescale 1ns/1ps
`default_nettype none
`include "accr_regs.vh"
module test_accr_top;
	logic        clk, resetn, rd, wr, wt, tick, mbit, mbd, sinv, soutv;
	logic        pu5, pu2, inv;
	logic [9:0]  addr;
	logic [31:0] wdata, rdata, q, v;
	logic [23:0] sin, sout;
	logic [3:0]  gcode;
	logic [5:0]  pdly;
	logic [7:0]  a;
	logic [7:0]  img[3] = '{8'h80, 8'h00, 8'h00};
	logic        hist[$];
	logic [31:0] seed = 32'ha147;
	int          num_errors, checks_done, i, j, n;

	accr_top accr_top_i
	(
		.CLK(clk),
		.RESETN(resetn),
		.AVS_ADDRESS(addr),
		.AVS_READ(rd),
		.AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wt),
		.MOD_TICK(tick),
		.MOD_BIT(mbit),
		.MOD_BIT_DELAYED(mbd),
		.SAMPLE_IN(sin),
		.SAMPLE_IN_VALID(sinv),
		.SAMPLE_OUT(sout),
		.SAMPLE_OUT_VALID(soutv),
		.CM_PULLUP_500K(pu5),
		.CM_PULLUP_250K(pu2),
		.CH4_FINE_GAIN_CODE(gcode),
		.CH4_PHASE_DELAY(pdly),
		.DATA_INVERT(inv)
	);

	// free running clock
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// stored bits of each register, none for unmapped
	function automatic logic [7:0] mask(input logic [7:0] x);
		return x == 8'h60 ? 8'hf0 : x == 8'h61 ? 8'hfc : x == 8'h62 ? 8'h34 : 8'h0;
	endfunction

	// expected sample: gain, clamp, then negate
	function automatic logic [23:0] model(input logic [23:0] x);
		logic signed [47:0] r;
		logic [15:0]        k;
		logic [15:0]        t[16];
		t = '{`ACCR_GAIN_M08, `ACCR_GAIN_M07, `ACCR_GAIN_M06, `ACCR_GAIN_M05,
			`ACCR_GAIN_M04, `ACCR_GAIN_M03, `ACCR_GAIN_M02, `ACCR_GAIN_M01,
			`ACCR_GAIN_UNITY, `ACCR_GAIN_P01, `ACCR_GAIN_P02, `ACCR_GAIN_P03,
			`ACCR_GAIN_P04, `ACCR_GAIN_P05, `ACCR_GAIN_P06, `ACCR_GAIN_P07};
		k = t[img[0][7:4]];
		r = ($signed(x) * $signed({1'b0, k})) >>> 14;
		if (r > 48'sh7fffff) r = 48'sh7fffff;
		if (r < -48'sh800000) r = -48'sh800000;
		if (img[2][2]) r = r == -48'sh800000 ? 48'sh7fffff : -r;
		return r[23:0];
	endfunction

	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] o);
		checks_done++;
		if (o !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", s, e, o);
		end
	endtask

	// one bus access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] x, input logic [7:0] d);
		addr <= {x, 2'h0};
		wr <= w;
		rd <= ~w;
		wdata <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wt !== 1'b0 && n < 20);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20)
		begin
			num_errors++;
			stop_test();
		end
		if (w && mask(x) != 8'h0) img[x - 8'h60] = d & mask(x);
		@(posedge clk);
	endtask

	// settings mirror lags the register by one edge
	task automatic outs();
		@(posedge clk);
		chk("settings", {img[0][7:4], img[1][7:2], img[2][2],
			img[2][5:4] == 2'h1, img[2][5:4] == 2'h2}, {gcode, pdly, inv, pu5, pu2});
	endtask

	// one sample through the gain stage
	task automatic samp(input logic [23:0] x);
		sin <= x;
		sinv <= 1'b1;
		@(posedge clk);
		sinv <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (soutv !== 1'b1 && n < 8);
		chk("sample", model(x), sout);
		if (n >= 8)
		begin
			num_errors++;
			stop_test();
		end
	endtask

	// reset pulse, then every register and setting at its reset value
	task automatic rst(input int c);
		resetn <= 1'b0;
		repeat (c) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		img = '{8'h80, 8'h00, 8'h00};
		for (i = 0; i < 3; i++)
		begin
			bus(1'b0, 8'h60 + i[7:0], 8'h0);
			chk("reset value", img[i], q);
		end
		outs();
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{clk, resetn, rd, wr, tick, mbit, sinv, addr, wdata, sin} = '0;
		rst(16);
		// random writes, reserved bits kept zero, unmapped index too
		for (i = 0; i < 30; i++)
		begin
			v = rnd();
			a = 8'h60 + {6'h0, v[9:8]};
			bus(1'b1, a, v[7:0] & mask(a));
			bus(1'b0, a, 8'h0);
			chk("readback", {24'h0, v[7:0] & mask(a)}, q);
			outs();
		end
		// mid-run reset brings back the reset values
		rst(2);
		for (i = 0; i < 4; i++)
		begin
			bus(1'b1, 8'h62, {2'h0, i[1:0], 1'b0, i[0], 2'h0});
			outs();
		end
		for (i = 0; i < 8; i++)
		begin
			j = i < 2 ? 0 : i < 4 ? 8 : i < 6 ? 15 : rnd() % 16;
			bus(1'b1, 8'h60, {j[3:0], 4'h0});
			bus(1'b1, 8'h62, {5'h0, i[0], 2'h0});
			samp(24'h7fffff);
			samp(24'h800000);
			v = rnd();
			samp(v[23:0]);
		end
		for (i = 0; i < 2; i++)
		begin
			bus(1'b1, 8'h61, i ? 8'hfc : 8'h0c);
			hist.delete();
			for (j = 0; j < img[1][7:2] + 8; j++)
			begin
				v = rnd();
				mbit <= v[0];
				tick <= 1'b1;
				hist.push_back(v[0]);
				repeat (4) @(posedge clk);
				tick <= 1'b0;
				repeat (4) @(posedge clk);
				if (j >= img[1][7:2])
					chk("delayed bit", hist[j - img[1][7:2]], mbd);
			end
		end
		stop_test();
	end
endmodule
bind accr_top accr_properties accr_properties_i (.*);
`default_nettype wire
